// ---- core/i2csb_consts.vh ----
// Constants for the I2C slave node with start-byte and reserved-address handling
// Behaviour
// - Nobody drives an acknowledge after the START byte; SDA stays released.
// - Receive logic resets on the repeated START, discarding the START byte.
// - Polling receivers may sample slowly until a low START-byte bit appears.
// - Never acknowledge or respond to legacy three-wire address 0000001X.
// - Legacy transfers end with STOP; every node then returns to idle.
// - Node supports fast-mode, receiving up to 400 kbit/s; reads are not served, so it never sends.
// - Node synchronizes to 400 kbit/s, stretching SCL low when not ready.
// - Node stays fully operable on 0 to 100 kbit/s standard-mode buses.
// - Slave address may be 7-bit or 10-bit, selected by a strap.
// - 7-bit and 10-bit nodes coexist on one bus without interference.
// - 10-bit scheme gives 1024 further addresses beyond the 7-bit space.
// - Any START or repeated START resets protocol state to expect address.
// - 10-bit first byte has upper bits 11110XX, XX being address MSBs.
`ifndef I2CSB_CONSTS_VH
`define I2CSB_CONSTS_VH
`define I2CSB_START_BYTE 8'h01
`define I2CSB_LEGACY_PFX 7'h01
`define I2CSB_TENBIT_PFX 5'h1E
`define I2CSB_GCALL_BYTE 8'h00
`define I2CSB_CLK_NS 100
`define I2CSB_FAST_BIT_NS 2500
// SCL low time at 400 kbit/s in cycles, rounded down
`define I2CSB_FAST_LOW_CYC ((`I2CSB_FAST_BIT_NS / 2) / `I2CSB_CLK_NS)
`define I2CSB_BUF_DEPTH 2
`endif

// ---- core/i2csb_buf.v ----
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/10ps
`default_nettype none
module i2csb_buf (
    input wire mclk,          // System clock
    input wire arst_n,        // Async reset, active low
    input wire [7:0] in_data, // Byte from the bus side
    input wire in_valid,      // Byte offered
    output wire in_ready,     // Room available
    output wire [7:0] out_data, // Oldest byte
    output wire out_valid,    // Byte available
    input wire out_ready      // Consumer takes byte
);
    reg [7:0] mem_ff [0:1];
    reg wr_ptr_ff;
    reg rd_ptr_ff;
    reg [1:0] cnt_ff;
    wire do_wr;
    wire do_rd;
    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
            mem_ff[0] <= 8'h00;
            mem_ff[1] <= 8'h00;
        end else begin
            if (do_wr) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (do_rd)
                rd_ptr_ff <= ~rd_ptr_ff;
            if (do_wr && !do_rd)
                cnt_ff <= cnt_ff + 2'h1;
            else if (do_rd && !do_wr)
                cnt_ff <= cnt_ff - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ---- core/i2csb_node.v ----
// I2C slave receiver: start byte, reserved addresses, 7/10-bit, stretching
`timescale 1ns/10ps
`default_nettype none
`include "i2csb_consts.vh"
module i2csb_node (
    input wire mclk,              // System clock, 10 MHz
    input wire arst_n,            // Async reset, active low
    input wire scl_in,            // SCL pin level
    output reg scl_oe_ff,         // High: pull SCL low (stretch)
    output wire scl_out,          // SCL drive level, always low
    input wire sda_in,            // SDA pin level
    output reg sda_oe_ff,         // High: pull SDA low (acknowledge)
    output wire sda_out,          // SDA drive level, always low
    input wire legacy_bus_enable_line, // Legacy three-wire enable line
    input wire ten_bit_mode,      // Strap: 1 selects 10-bit address
    input wire [9:0] own_addr,    // Strap: own slave address
    output reg [7:0] rx_data_ff,  // Received data byte
    output reg rx_valid_ff,       // Data byte available
    input wire rx_ready,          // Consumer takes byte
    output reg addressed_ff,      // Node selected as receiver
    output reg legacy_ff,         // Legacy transfer in progress
    output reg start_seen_ff      // Pulse: start byte was discarded
);
    // Open-drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg [1:0] leg_sync_ff;
    reg scl_d_ff;
    reg sda_d_ff;
    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire scl_rise = scl_s && !scl_d_ff;
    wire scl_fall = !scl_s && scl_d_ff;
    wire start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    wire stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            leg_sync_ff <= 2'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            leg_sync_ff <= {leg_sync_ff[0], legacy_bus_enable_line};
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decoding
    function is_legacy;
        input [7:0] b;
        begin
            is_legacy = (b[7:1] == `I2CSB_LEGACY_PFX);
        end
    endfunction
    function is_tenbit_hi;
        input [7:0] b;
        input [9:0] a;
        begin
            is_tenbit_hi = (b[7:3] == `I2CSB_TENBIT_PFX) && (b[2:1] == a[9:8]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte engine
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_ADDR2 = 6'h04;
    localparam [5:0] ST_DATA = 6'h08;
    localparam [5:0] ST_SKIP = 6'h10;
    localparam [5:0] ST_LEG = 6'h20;

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg [7:0] shreg_ff;
    reg [3:0] bitcnt_ff;
    reg ack_ff;
    reg tenhi_ok_ff;
    reg [7:0] nxt_byte;
    reg [7:0] buf_in_ff;
    reg buf_in_valid_ff;
    wire buf_in_ready;
    wire [7:0] buf_out_data;
    wire buf_out_valid;
    wire buf_out_ready;
    // Stall on a full buffer by stretching SCL; no byte is ever dropped
    wire stall = (state_ff == ST_DATA) && (!buf_in_ready || buf_in_valid_ff);

    always @* begin
        nxt_byte = {shreg_ff[6:0], sda_s};
    end

    // Decision on the completed byte; only used at the 8th SCL fall
    always @* begin
        nxt_state = state_ff;
        if (state_ff == ST_ADDR) begin
            if (shreg_ff == `I2CSB_START_BYTE) begin
                nxt_state = ST_SKIP;
            end else if (is_legacy(shreg_ff)) begin
                nxt_state = ST_LEG;
            end else if (ten_bit_mode) begin
                // 11110XX prefix carries upper bits; reads are not served
                if (is_tenbit_hi(shreg_ff, own_addr) && !shreg_ff[0]) begin
                    nxt_state = ST_ADDR2;
                end else begin
                    nxt_state = ST_SKIP;
                end
            end else if (shreg_ff[7:1] == own_addr[6:0] && !shreg_ff[0]) begin
                nxt_state = ST_DATA;
            end else begin
                nxt_state = ST_SKIP;
            end
        end else if (state_ff == ST_ADDR2) begin
            if (shreg_ff == own_addr[7:0]) begin
                nxt_state = ST_DATA;
            end else begin
                nxt_state = ST_SKIP;
            end
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            shreg_ff <= 8'h00;
            bitcnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            tenhi_ok_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            addressed_ff <= 1'b0;
            legacy_ff <= 1'b0;
            start_seen_ff <= 1'b0;
            buf_in_ff <= 8'h00;
            buf_in_valid_ff <= 1'b0;
        end else begin
            start_seen_ff <= 1'b0;
            if (buf_in_valid_ff && buf_in_ready)
                buf_in_valid_ff <= 1'b0;
            if (start_det) begin
                // Any START resets the protocol; a preceding start byte is
                // thereby discarded
                state_ff <= ST_ADDR;
                bitcnt_ff <= 4'h0;
                ack_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
                scl_oe_ff <= 1'b0;
                addressed_ff <= 1'b0;
                legacy_ff <= 1'b0;
            end else if (stop_det) begin
                // STOP ends every transfer, legacy ones too
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
                scl_oe_ff <= 1'b0;
                addressed_ff <= 1'b0;
                legacy_ff <= 1'b0;
                tenhi_ok_ff <= 1'b0;
            end else if (state_ff == ST_LEG || state_ff == ST_IDLE) begin
                // Legacy frames carry no acknowledge; stay silent
                sda_oe_ff <= 1'b0;
                legacy_ff <= (state_ff == ST_LEG) && leg_sync_ff[1];
            end else begin
                // Sampling on SCL edges keeps pace at any rate up to
                // 400 kbit/s
                if (scl_rise && bitcnt_ff < 4'h8) begin
                    shreg_ff <= nxt_byte;
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                end
                if (scl_fall && bitcnt_ff == 4'h8) begin
                    bitcnt_ff <= 4'h9;
                    state_ff <= nxt_state;
                    // Start byte: no ack, wait for Sr
                    start_seen_ff <= (state_ff == ST_ADDR) &&
                                     (shreg_ff == `I2CSB_START_BYTE);
                    ack_ff <= (nxt_state == ST_ADDR2) ||
                              (nxt_state == ST_DATA);
                    addressed_ff <= (nxt_state == ST_DATA);
                    if (state_ff == ST_ADDR2 && nxt_state == ST_DATA)
                        tenhi_ok_ff <= 1'b1;
                    if (state_ff == ST_DATA) begin
                        buf_in_ff <= shreg_ff;
                        buf_in_valid_ff <= 1'b1;
                    end
                    sda_oe_ff <= (nxt_state == ST_ADDR2) ||
                                 (nxt_state == ST_DATA);
                end
                if (scl_fall && bitcnt_ff == 4'h9) begin
                    bitcnt_ff <= 4'h0;
                    sda_oe_ff <= 1'b0;
                end
                // Hold SCL low while the buffer is full
                scl_oe_ff <= stall && scl_fall ? 1'b1 :
                             (scl_oe_ff && stall);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and output register
    i2csb_buf u_buf (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_data(buf_in_ff),
        .in_valid(buf_in_valid_ff),
        .in_ready(buf_in_ready),
        .out_data(buf_out_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready)
    );
    assign buf_out_ready = !rx_valid_ff || rx_ready;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
        end else if (buf_out_ready) begin
            rx_data_ff <= buf_out_data;
            rx_valid_ff <= buf_out_valid;
        end
    end
endmodule
`default_nettype wire

// ---- bench/i2csb_node_properties.sv ----
// Checker for the start-byte aware receiver node
`timescale 1ns/10ps
`default_nettype none
module i2csb_node_props (
    input wire mclk, // clock
    input wire arst_n, // reset
    input wire scl_oe_ff, // stretch
    input wire sda_oe_ff, // ack drive
    input wire legacy_bus_enable_line, // legacy enable
    input wire [7:0] rx_data_ff, // byte
    input wire rx_valid_ff, // byte valid
    input wire rx_ready, // byte taken
    input wire addressed_ff, // selected
    input wire legacy_ff, // legacy frame
    input wire start_seen_ff // start byte pulse
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence s_en_low;
        !legacy_bus_enable_line [*4];
    endsequence
    sequence s_ack_done;
        ##[1:200] !sda_oe_ff;
    endsequence
    a_reset_idle: assert property ($rose(arst_n) |-> !sda_oe_ff && !scl_oe_ff && !rx_valid_ff)
        else $error("outputs busy after reset");
    a_ack_release: assert property ($rose(sda_oe_ff) |-> s_ack_done)
        else $error("ack held too long");
    a_start_pulse: assert property (start_seen_ff |=> !start_seen_ff)
        else $error("start pulse too long");
    a_start_silent: assert property (start_seen_ff |-> !sda_oe_ff && !addressed_ff)
        else $error("start byte answered");
    a_legacy_quiet: assert property (legacy_ff |-> !sda_oe_ff && !addressed_ff)
        else $error("legacy frame answered");
    a_legacy_enable: assert property (s_en_low |-> !legacy_ff)
        else $error("legacy state without enable");
    a_rx_hold: assert property (rx_valid_ff && !rx_ready |=> rx_valid_ff && $stable(rx_data_ff))
        else $error("byte lost while stalled");
    a_stretch_full: assert property (scl_oe_ff |-> rx_valid_ff || $past(rx_valid_ff))
        else $error("stretch without full buffer");
endmodule
bind i2csb_node i2csb_node_props u_props (.mclk(mclk), .arst_n(arst_n),
    .scl_oe_ff(scl_oe_ff), .sda_oe_ff(sda_oe_ff), .rx_ready(rx_ready),
    .legacy_bus_enable_line(legacy_bus_enable_line), .legacy_ff(legacy_ff),
    .rx_data_ff(rx_data_ff), .rx_valid_ff(rx_valid_ff),
    .addressed_ff(addressed_ff), .start_seen_ff(start_seen_ff));
`default_nettype wire

// ---- bench/i2csb_mst.sv ----
// Bus master model: open-drain SCL and SDA, honours clock stretching
`timescale 1ns/10ps
`default_nettype none
module i2csb_mst (
    input wire logic mclk, // pacing clock
    input wire logic scl, // resolved SCL
    input wire logic sda, // resolved SDA
    output logic scl_oe = 0, // pull SCL low
    output logic sda_oe = 0 // pull SDA low
);
    int qn = 2;
    int tmo = 0;
    task automatic q();
        repeat (qn) @(negedge mclk);
    endtask
    // Bounded so a slave holding SCL forever cannot hang the run
    task automatic rise();
        scl_oe = 0;
        for (int n = 0; n < 3000 && scl !== 1'b1; n++) @(negedge mclk);
        if (scl !== 1'b1) tmo++;
    endtask
    task automatic bit_io(input logic b, output logic s);
        q();
        sda_oe = !b;
        q();
        rise();
        q();
        q();
        s = sda;
        scl_oe = 1;
    endtask
    // p high: START or repeated START; p low: STOP
    task automatic cond(input logic p);
        q();
        sda_oe = !p;
        q();
        rise();
        q();
        sda_oe = p;
        q();
        scl_oe = p;
    endtask
    task automatic raw(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        raw(d);
        bit_io(1'b1, ack);
        ack = !ack;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_i2csb_node.sv ----
// Self-checking bench for the receiver node
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_start_byte_reserved_address_handling;
    logic mclk = 0, arst_n = 0, rx_ready = 0, hold = 0, len = 0, tbm = 0;
    logic sb = 0, lg = 0, st = 0, ack, m_scl_oe, m_sda_oe;
    logic [9:0] own = 10'h000;
    logic [31:0] rs = 32'hE4A2;
    logic [7:0] got[$], exp[$];
    int fail_count = 0, checked = 0;
    wire logic scl_oe_ff, sda_oe_ff, scl_out, sda_out, rx_valid_ff;
    wire logic addressed_ff, legacy_ff, start_seen_ff;
    wire logic [7:0] rx_data_ff;
    wire logic scl = ~(scl_oe_ff | m_scl_oe);
    wire logic sda = ~(sda_oe_ff | m_sda_oe);
    i2csb_mst u_mst (.mclk(mclk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe),
        .sda_oe(m_sda_oe));
    i2csb_node u_dut (.mclk(mclk), .arst_n(arst_n), .scl_in(scl),
        .scl_oe_ff(scl_oe_ff), .scl_out(scl_out), .sda_in(sda),
        .sda_oe_ff(sda_oe_ff), .sda_out(sda_out), .ten_bit_mode(tbm),
        .legacy_bus_enable_line(len), .own_addr(own), .rx_ready(rx_ready),
        .rx_data_ff(rx_data_ff), .rx_valid_ff(rx_valid_ff),
        .addressed_ff(addressed_ff), .legacy_ff(legacy_ff),
        .start_seen_ff(start_seen_ff));
    function automatic logic [31:0] xrand();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk1(input string n, input logic e, input logic s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e, s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] d, input logic e);
        u_mst.send(d, ack);
        chk1("ack", e, ack);
    endtask
    task automatic dat(input int n);
        logic [7:0] d;
        repeat (n) begin
            d = 8'(xrand());
            exp.push_back(d);
            xfer(d, 1'b1);
        end
    endtask
    task automatic drain(input string n);
        for (int i = 0; i < 5000 && got.size() < exp.size(); i++) @(negedge mclk);
        chk8("rx_count", 8'(exp.size()), 8'(got.size()));
        chk8("scl_timeouts", 8'h00, 8'(u_mst.tmo));
        chk1("scl_out", 1'b0, scl_out);
        chk1("sda_out", 1'b0, sda_out);
        if (u_mst.tmo != 0)
            give_verdict();
        if (got.size() != exp.size())
            give_verdict();
        foreach (exp[i]) chk8("rx_data", exp[i], got[i]);
        got.delete();
        exp.delete();
        $display("test %s done", n);
    endtask
    initial begin
        forever #50 mclk = ~mclk;
    end
    // Random consumer stalls exercise the two-entry buffer
    always @(negedge mclk) rx_ready <= !hold && xrand() % 2 == 1;
    always @(posedge mclk) begin
        if (rx_valid_ff === 1'b1 && rx_ready === 1'b1)
            got.push_back(rx_data_ff);
        if (start_seen_ff === 1'b1) sb <= 1;
        if (legacy_ff === 1'b1) lg <= 1;
        if (scl_oe_ff === 1'b1) st <= 1;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        chk1("run_done", 1'b1, 1'b0);
        give_verdict();
    end
    initial begin
        own = {3'h0, 7'h08 + 7'(xrand() % 112)};
        repeat (16) @(negedge mclk);
        arst_n = 1;
        repeat (4) @(negedge mclk);
        u_mst.cond(1);
        xfer(8'h01, 0);
        u_mst.cond(1);
        xfer({own[6:0], 1'b0}, 1);
        chk1("start_seen", 1, sb);
        dat(2);
        u_mst.cond(0);
        drain("start_byte");
        for (int dr = 0; dr < 2; dr++) begin
            lg = 0;
            u_mst.cond(1);
            xfer({7'h01, dr[0]}, 0);
            len = 1;
            u_mst.raw(8'(xrand()));
            chk1("legacy", 1, lg);
            chk1("addressed", 0, addressed_ff);
            u_mst.cond(0);
            len = 0;
        end
        u_mst.cond(1);
        xfer({own[6:0], 1'b0}, 1);
        dat(1);
        u_mst.cond(0);
        drain("legacy");
        tbm = 1;
        own = 10'(xrand());
        u_mst.cond(1);
        xfer({5'h1E, own[9:8], 1'b0}, 1);
        xfer(own[7:0] ^ 8'h01, 0);
        u_mst.cond(1);
        xfer({5'h1E, own[9:8], 1'b0}, 1);
        xfer(own[7:0], 1);
        dat(1);
        u_mst.cond(0);
        drain("ten_bit");
        hold = 1;
        fork
            begin
                u_mst.cond(1);
                xfer({5'h1E, own[9:8], 1'b0}, 1);
                xfer(own[7:0], 1);
                dat(4);
                u_mst.cond(0);
            end
            begin
                repeat (800) @(negedge mclk);
                hold = 0;
            end
        join
        chk1("stretched", 1, st);
        drain("stretch");
        u_mst.qn = 25;
        u_mst.cond(1);
        xfer({5'h1E, own[9:8], 1'b0}, 1);
        xfer(own[7:0], 1);
        dat(2);
        u_mst.cond(0);
        drain("standard");
        give_verdict();
    end
endmodule
`default_nettype wire
